// ### core/rtw_seq.sv
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/10ps
module rtw_seq import rtw_pkg::*; #(
  parameter int WAKE_COLD_P = WAKE_COLD_CYC,
  parameter int XOSC_P = XOSC_CYC,
  parameter int PLL_INIT_P = PLL_INIT_CYC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Register bus
  input wire rtw_apb_in_type apb_i,
  output rtw_apb_out_type apb_o,
  // Radio front end and modem
  input wire rtw_radio_in_type radio_i,
  output rtw_radio_out_type radio_o
);

  // Refuse counts that the timer cannot hold
  if (WAKE_COLD_P < 1 || XOSC_P < 1 || PLL_INIT_P < 2 ||
      RST_WAKE_CYC + XOSC_P >= 2 ** TMR_W || WAKE_COLD_P >= 2 ** TMR_W ||
      PLL_INIT_P >= 2 ** TMR_W) begin : g_bad_cfg
    $error("rtw_seq: timer counts out of range");
  end

  // Regulator share of the ramp; a shortened ramp keeps at least one cycle
  localparam int ANALOG_REGULATOR_SHARE = PLL_INIT_CYC - PLL_FAST_CYC;
  localparam int PLL_FAST_P = (PLL_INIT_P > ANALOG_REGULATOR_SHARE) ? PLL_INIT_P - ANALOG_REGULATOR_SHARE : 1;

  // Reset image: clock-only state, all fields at default
  localparam rtw_regs_type REGS_RST = '{
    state: ST_OFF, tmr: '0, rst_cnt: '0, cmd: CMD_RST, mask: MASK_RST,
    ext_mode: 1'b0, pin: PIN_RST, trig_d: 1'b0, was_sleep: 1'b0,
    pend_rx: 1'b0, pend_off: 1'b0, apb: '0, radio: '0};

  rtw_regs_type r; // Registered state
  rtw_regs_type n; // Next state
  logic cmd_wr; // Command written this cycle and accepted
  logic [4:0] cmd_val; // Written command code
  logic reg_wr; // APB write completes this cycle
  logic trig_rise; // Trigger bit went 0 to 1
  logic busy; // Receive or transmit in progress
  logic [IRQ_N-1:0] ev; // Raw event pulses before gating

  // State readback code, 1F while a transition runs
  function automatic logic [4:0] sts_code(input rtw_state_type s);
    logic [4:0] c;
    c = STS_TRANS;
    case (s)
      ST_SLEEP: c = STS_SLEEP;
      ST_OFF: c = STS_OFF;
      ST_PLL_ON: c = STS_PLL_ON;
      ST_RX_ON: c = STS_RX_ON;
      ST_BUSY_RX: c = STS_BUSY_RX;
      ST_TX_RAMP, ST_BUSY_TX: c = STS_BUSY_TX;
      default: c = STS_TRANS;
    endcase
    return c;
  endfunction

  // Next-state logic: bus slave, reset procedure and state machine
  always_comb begin
    n = r;
    ev = '0;
    n.apb.pready = 1'b0;
    n.apb.pslverr = 1'b0;
    n.radio.shr_start = 1'b0;
    reg_wr = apb_i.psel && apb_i.penable && r.apb.pready && apb_i.pwrite;
    cmd_val = apb_i.pwdata[4:0];
    // Commands are dropped while a transition runs; software must poll
    cmd_wr = reg_wr && (apb_i.paddr == ADDR_CMD) && (sts_code(r.state) != STS_TRANS);
    trig_rise = r.pin[PIN_TRIG_BIT] && !r.trig_d;
    busy = (r.state == ST_BUSY_RX) || (r.state == ST_TX_RAMP) || (r.state == ST_BUSY_TX);
    n.trig_d = r.pin[PIN_TRIG_BIT];
    if (r.tmr != '0) begin
      n.tmr = r.tmr - 1'b1;
    end

    // Reset bit wins over everything; pin register itself is kept
    if (r.pin[PIN_RST_BIT] && r.state != ST_RST_HOLD) begin
      n.state = ST_RST_HOLD;
      n.rst_cnt = 2'(RST_HOLD_CYC - 1);
      n.was_sleep = (r.state == ST_SLEEP);
      n.cmd = CMD_RST;
      n.mask = MASK_RST;
      n.ext_mode = 1'b0;
      n.pend_rx = 1'b0;
      n.pend_off = 1'b0;
      n.tmr = '0;
    end else if (r.state == ST_RST_HOLD) begin
      // Self-release after the hold, then rerun the wake sequence
      if (r.rst_cnt == '0) begin
        n.pin[PIN_RST_BIT] = 1'b0;
        n.state = ST_RST_WAKE;
        // A reset from sleep also waits for the oscillator
        n.tmr = r.was_sleep ? TMR_W'(RST_WAKE_CYC + XOSC_P - 1) : TMR_W'(RST_WAKE_CYC - 1);
      end else begin
        n.rst_cnt = r.rst_cnt - 1'b1;
      end
    end else if (cmd_wr && cmd_val == CMD_FORCE_OFF && r.state != ST_SLEEP && r.state != ST_WAKE &&
                 r.state != ST_RST_WAKE) begin
      // Forced off aborts any activity at once
      n.state = ST_OFF;
      n.pend_rx = 1'b0;
      n.pend_off = 1'b0;
    end else if (cmd_wr && cmd_val == CMD_FORCE_PLL && (busy || r.state == ST_RX_ON)) begin
      // Fast return to synthesizer-on without dropping the regulator
      n.state = ST_PLL_ON;
      n.pend_rx = 1'b0;
      n.pend_off = 1'b0;
    end else begin
      // Listen commands during transmit and off commands during any activity are remembered, not acted on
      if (cmd_wr && busy) begin
        if (cmd_val == CMD_RX_ON && r.state != ST_BUSY_RX) begin
          n.pend_rx = 1'b1;
        end else if (cmd_val == CMD_OFF) begin
          n.pend_off = 1'b1;
        end
      end
      case (r.state)
        ST_SLEEP: begin
          // Clearing the trigger wakes; warm oscillator shortens it
          if (!r.pin[PIN_TRIG_BIT]) begin
            n.state = ST_WAKE;
            n.tmr = radio_i.xosc_running ? TMR_W'(WAKE_WARM_CYC - 1) : TMR_W'(WAKE_COLD_P - 1);
          end
        end
        ST_WAKE, ST_RST_WAKE: begin
          // Filter tuning runs here; wake event on arrival
          if (r.tmr == '0) begin
            n.state = ST_OFF;
            ev[IRQ_WAKE] = 1'b1;
          end
        end
        ST_OFF: begin
          if (trig_rise) begin
            n.state = ST_SLEEP;
          end else if (cmd_wr && cmd_val == CMD_PLL_ON) begin
            n.state = ST_PLL_RAMP;
            // Regulator ramp skipped when the converter already runs it
            n.tmr = radio_i.adc_analog_regulator_on ? TMR_W'(PLL_FAST_P - 1) : TMR_W'(PLL_INIT_P - 1);
          end else if (cmd_wr && cmd_val == CMD_RX_ON) begin
            // Listen entered at once; regulator ramps beneath it
            n.state = ST_RX_ON;
          end
        end
        ST_PLL_RAMP: begin
          if (r.tmr == '0) begin
            n.state = ST_PLL_ON;
            ev[IRQ_LOCK] = 1'b1;
          end
        end
        ST_PLL_ON: begin
          // Only this state accepts a transmit start
          if (trig_rise || (cmd_wr && cmd_val == CMD_TX_START)) begin
            n.state = ST_TX_RAMP;
            n.tmr = TMR_W'(TX_RAMP_CYC - 1);
          end else if (cmd_wr && cmd_val == CMD_RX_ON) begin
            n.state = ST_RX_ON;
          end else if (cmd_wr && cmd_val == CMD_OFF) begin
            n.state = ST_OFF;
          end
        end
        ST_RX_ON: begin
          if (radio_i.shr_detect) begin
            n.state = ST_BUSY_RX;
          end else if (cmd_wr && cmd_val == CMD_PLL_ON) begin
            n.state = ST_PLL_ON;
          end else if (cmd_wr && cmd_val == CMD_OFF) begin
            n.state = ST_OFF;
          end
        end
        ST_BUSY_RX: begin
          ev[IRQ_RX_START] = radio_i.phr_valid;
          ev[IRQ_ADDR] = radio_i.addr_match;
          if (radio_i.rx_end) begin
            // Extended mode reports only filtered frames with good FCS
            ev[IRQ_RX_DONE] = !r.ext_mode || (radio_i.addr_pass && radio_i.fcs_ok);
            n.state = (r.pend_off || n.pend_off) ? ST_OFF : ST_RX_ON;
            n.pend_off = 1'b0;
          end
        end
        ST_TX_RAMP: begin
          // Synthesizer shifted and amplifier ramping during the wait
          if (r.tmr == '0) begin
            if (radio_i.tx_len == 7'h00) begin
              n.state = ST_PLL_ON;
              n.pend_rx = 1'b0;
              n.pend_off = 1'b0;
            end else begin
              n.state = ST_BUSY_TX;
              n.radio.shr_start = 1'b1;
            end
          end
        end
        ST_BUSY_TX: begin
          if (radio_i.tx_done) begin
            n.state = ST_TX_SETTLE;
            n.tmr = TMR_W'(TX_SETTLE_CYC - 1);
            ev[IRQ_TX_DONE] = 1'b1;
          end
        end
        ST_TX_SETTLE: begin
          // Held commands are carried out once the synthesizer settles
          if (r.tmr == '0) begin
            if (r.pend_off) begin
              n.state = ST_OFF;
            end else if (r.pend_rx) begin
              n.state = ST_RX_ON;
            end else begin
              n.state = ST_PLL_ON;
            end
            n.pend_rx = 1'b0;
            n.pend_off = 1'b0;
          end
        end
        default: begin
          n.state = ST_OFF;
        end
      endcase
    end

    // Register writes; a software set wins over the hardware release
    if (reg_wr) begin
      if (apb_i.paddr == ADDR_CMD) begin
        // Unknown codes are stored for readback but drive nothing
        n.cmd = cmd_val;
      end else if (apb_i.paddr == ADDR_PIN) begin
        n.pin = apb_i.pwdata[1:0];
      end else if (apb_i.paddr == ADDR_MASK) begin
        n.mask = apb_i.pwdata[IRQ_N-1:0];
      end else if (apb_i.paddr == ADDR_CFG) begin
        n.ext_mode = apb_i.pwdata[CFG_EXT_BIT];
      end
    end

    // Setup phase: prepare read data, answer in the access phase
    if (apb_i.psel && !apb_i.penable && !r.apb.pready) begin
      n.apb.pready = 1'b1;
      if (apb_i.paddr == ADDR_CMD) begin
        n.apb.prdata = {27'h0000000, r.cmd};
      end else if (apb_i.paddr == ADDR_STATUS) begin
        n.apb.prdata = {27'h0000000, sts_code(r.state)};
      end else if (apb_i.paddr == ADDR_PIN) begin
        n.apb.prdata = {30'h00000000, r.pin};
      end else if (apb_i.paddr == ADDR_MASK) begin
        n.apb.prdata = {26'h0000000, r.mask};
      end else if (apb_i.paddr == ADDR_CFG) begin
        n.apb.prdata = {31'h00000000, r.ext_mode};
      end else begin
        n.apb.prdata = 32'h00000000;
        n.apb.pslverr = 1'b1;
      end
    end

    // Events reach the pins only when masked in and globally enabled
    n.radio.irq = ev & n.mask & {IRQ_N{radio_i.gie}};

    // Analog controls follow the next state
    n.radio.xosc_en = (n.state != ST_SLEEP);
    n.radio.ftn_cal = (n.state == ST_WAKE) || (n.state == ST_RST_WAKE);
    n.radio.analog_regulator_en = !(n.state inside {ST_SLEEP, ST_WAKE, ST_RST_HOLD, ST_RST_WAKE, ST_OFF});
    n.radio.rx_en = (n.state == ST_RX_ON) || (n.state == ST_BUSY_RX);
    n.radio.synth_tx = (n.state == ST_TX_RAMP) || (n.state == ST_BUSY_TX);
    n.radio.pa_en = (n.state == ST_TX_RAMP) || (n.state == ST_BUSY_TX);
  end

  // State register, main reset gives the clock-only state
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      r <= REGS_RST;
    end else begin
      r <= n;
    end
  end

  assign apb_o = r.apb;
  assign radio_o = r.radio;

  // Helper: cycles spent in the current state, for checks only
  logic [TMR_W-1:0] dwell;
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dwell <= '0;
    end else if (n.state != r.state) begin
      dwell <= '0;
    end else begin
      dwell <= dwell + 1'b1;
    end
  end

  a_tx_only_synth: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (n.state == ST_TX_RAMP && r.state != ST_TX_RAMP) |-> r.state == ST_PLL_ON)
    else $error("transmit started outside synthesizer-on");

  a_trig_starts_tx: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (r.state == ST_PLL_ON && r.pin[PIN_TRIG_BIT] && !r.trig_d && !r.pin[PIN_RST_BIT] && !cmd_wr)
    |=> r.state == ST_TX_RAMP && radio_o.pa_en)
    else $error("trigger rise did not start transmit");

  a_tx_ramp_time: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (r.state == ST_TX_RAMP && n.state == ST_BUSY_TX) |-> dwell == TMR_W'(TX_RAMP_CYC - 1))
    else $error("transmit ramp length wrong");

  a_zero_len_abort: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (r.state == ST_TX_RAMP && r.tmr == '0 && radio_i.tx_len == 7'h00 && !r.pin[PIN_RST_BIT] && !cmd_wr)
    |=> r.state == ST_PLL_ON && !radio_o.shr_start)
    else $error("zero length frame not aborted");

  a_tx_done_irq: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (r.state == ST_BUSY_TX && radio_i.tx_done && n.mask[IRQ_TX_DONE] && radio_i.gie &&
     !r.pin[PIN_RST_BIT] && !cmd_wr)
    |=> radio_o.irq[IRQ_TX_DONE] && !radio_o.pa_en ##1 !radio_o.irq[IRQ_TX_DONE])
    else $error("transmit done irq or amplifier wrong");

  a_settle_time: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (r.state == ST_TX_SETTLE && n.state != ST_TX_SETTLE && !r.pin[PIN_RST_BIT] && !cmd_wr)
    |-> dwell == TMR_W'(TX_SETTLE_CYC - 1))
    else $error("settle time wrong");

  a_rx_held: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (r.state == ST_TX_SETTLE && r.tmr == '0 && r.pend_rx && !r.pend_off && !r.pin[PIN_RST_BIT] && !cmd_wr)
    |=> r.state == ST_RX_ON)
    else $error("held listen command lost");

  a_rst_clears: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    $rose(r.state == ST_RST_HOLD) |-> r.mask == MASK_RST && r.cmd == CMD_RST && !r.ext_mode)
    else $error("transceiver reset left registers set");

  a_rst_release: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    $rose(r.state == ST_RST_HOLD) |-> (r.state == ST_RST_HOLD) [*3] ##1 r.state == ST_RST_WAKE)
    else $error("reset not released after three cycles");

  a_irq_gated: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (radio_o.irq != '0) |-> $past(radio_i.gie) && ((radio_o.irq & ~r.mask) == '0))
    else $error("irq raised while masked or disabled");

  a_listen_at_once: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (r.state == ST_OFF && cmd_wr && cmd_val == CMD_RX_ON && !trig_rise && !r.pin[PIN_RST_BIT])
    |=> r.state == ST_RX_ON && radio_o.rx_en)
    else $error("listen not entered at once");

  a_force_off_now: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (busy && cmd_wr && cmd_val == CMD_FORCE_OFF && !r.pin[PIN_RST_BIT])
    |=> r.state == ST_OFF && !radio_o.pa_en && !radio_o.rx_en)
    else $error("forced off did not abort at once");

  a_plain_off_held: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (r.state == ST_BUSY_RX && cmd_wr && cmd_val == CMD_OFF && !radio_i.rx_end && !r.pin[PIN_RST_BIT])
    |=> r.state == ST_BUSY_RX && r.pend_off)
    else $error("plain off not held during reception");

  a_wake_irq: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    ((r.state == ST_WAKE || r.state == ST_RST_WAKE) && r.tmr == '0 && !r.pin[PIN_RST_BIT])
    |=> r.state == ST_OFF && radio_o.irq[IRQ_WAKE] == (r.mask[IRQ_WAKE] && $past(radio_i.gie)))
    else $error("wake irq or clock-only entry wrong");

  a_regulator_skip: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (r.state == ST_OFF && cmd_wr && cmd_val == CMD_PLL_ON && !trig_rise && !r.pin[PIN_RST_BIT])
    |=> r.state == ST_PLL_RAMP && radio_o.analog_regulator_en && (r.tmr < TMR_W'(PLL_INIT_P - 1)) == $past(radio_i.adc_analog_regulator_on))
    else $error("regulator ramp not skipped or not started");

  a_listen_from_synth: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (r.state == ST_PLL_ON && cmd_wr && cmd_val == CMD_RX_ON && !trig_rise && !r.pin[PIN_RST_BIT])
    |=> r.state == ST_RX_ON && radio_o.rx_en)
    else $error("listen from synthesizer-on refused");

endmodule

// ### core/rtw_pkg.sv
package rtw_pkg;

  // Clock rate and documented times in ns
  localparam int CLK_MHZ = 50;
  localparam int T_TX_RAMP_NS = 16000;
  localparam int T_TX_SETTLE_NS = 32000;
  localparam int T_WAKE_COLD_NS = 240000;
  localparam int T_WAKE_WARM_NS = 25000;
  localparam int T_RST_WAKE_NS = 37000;
  localparam int T_XOSC_NS = 215000;
  localparam int T_PLL_INIT_NS = 110000;
  localparam int T_ANALOG_REGULATOR_NS = 60000;

  // Cycle counts, least times rounded up
  localparam int TX_RAMP_CYC = (T_TX_RAMP_NS * CLK_MHZ + 999) / 1000;
  localparam int TX_SETTLE_CYC = (T_TX_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_COLD_CYC = (T_WAKE_COLD_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_WARM_CYC = (T_WAKE_WARM_NS * CLK_MHZ + 999) / 1000;
  localparam int RST_WAKE_CYC = (T_RST_WAKE_NS * CLK_MHZ + 999) / 1000;
  localparam int XOSC_CYC = (T_XOSC_NS * CLK_MHZ + 999) / 1000;
  localparam int PLL_INIT_CYC = (T_PLL_INIT_NS * CLK_MHZ + 999) / 1000;
  localparam int PLL_FAST_CYC = ((T_PLL_INIT_NS - T_ANALOG_REGULATOR_NS) * CLK_MHZ + 999) / 1000;
  localparam int RST_HOLD_CYC = 3;
  localparam int TMR_W = 14;

  // Register byte offsets
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_PIN = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0c;
  localparam logic [7:0] ADDR_CFG = 8'h10;

  // Field positions and reset values
  localparam int PIN_TRIG_BIT = 0;
  localparam int PIN_RST_BIT = 1;
  localparam int CFG_EXT_BIT = 0;
  localparam logic [4:0] CMD_RST = 5'h00;
  localparam logic [5:0] MASK_RST = 6'h00;
  localparam logic [1:0] PIN_RST = 2'h0;

  // Interrupt vector bit positions
  localparam int IRQ_LOCK = 0;
  localparam int IRQ_RX_START = 1;
  localparam int IRQ_RX_DONE = 2;
  localparam int IRQ_TX_DONE = 3;
  localparam int IRQ_ADDR = 4;
  localparam int IRQ_WAKE = 5;
  localparam int IRQ_N = 6;

  // State command field codes
  localparam logic [4:0] CMD_NOP = 5'h00;
  localparam logic [4:0] CMD_TX_START = 5'h02;
  localparam logic [4:0] CMD_FORCE_OFF = 5'h03;
  localparam logic [4:0] CMD_FORCE_PLL = 5'h04;
  localparam logic [4:0] CMD_RX_ON = 5'h06;
  localparam logic [4:0] CMD_OFF = 5'h08;
  localparam logic [4:0] CMD_PLL_ON = 5'h09;

  // State readback codes
  localparam logic [4:0] STS_BUSY_RX = 5'h01;
  localparam logic [4:0] STS_BUSY_TX = 5'h02;
  localparam logic [4:0] STS_RX_ON = 5'h06;
  localparam logic [4:0] STS_OFF = 5'h08;
  localparam logic [4:0] STS_PLL_ON = 5'h09;
  localparam logic [4:0] STS_SLEEP = 5'h0f;
  localparam logic [4:0] STS_TRANS = 5'h1f;

  typedef enum logic [11:0] {
    ST_SLEEP = 12'h001,
    ST_WAKE = 12'h002,
    ST_RST_HOLD = 12'h004,
    ST_RST_WAKE = 12'h008,
    ST_OFF = 12'h010,
    ST_PLL_RAMP = 12'h020,
    ST_PLL_ON = 12'h040,
    ST_RX_ON = 12'h080,
    ST_BUSY_RX = 12'h100,
    ST_TX_RAMP = 12'h200,
    ST_BUSY_TX = 12'h400,
    ST_TX_SETTLE = 12'h800
  } rtw_state_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } rtw_apb_in_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rtw_apb_out_type;

  typedef struct packed {
    logic gie;
    logic xosc_running;
    logic adc_analog_regulator_on;
    logic shr_detect;
    logic phr_valid;
    logic addr_match;
    logic rx_end;
    logic addr_pass;
    logic fcs_ok;
    logic tx_done;
    logic [6:0] tx_len;
  } rtw_radio_in_type;

  typedef struct packed {
    logic xosc_en;
    logic ftn_cal;
    logic analog_regulator_en;
    logic rx_en;
    logic synth_tx;
    logic pa_en;
    logic shr_start;
    logic [IRQ_N-1:0] irq;
  } rtw_radio_out_type;

  typedef struct packed {
    rtw_state_type state;
    logic [TMR_W-1:0] tmr;
    logic [1:0] rst_cnt;
    logic [4:0] cmd;
    logic [5:0] mask;
    logic ext_mode;
    logic [1:0] pin;
    logic trig_d;
    logic was_sleep;
    logic pend_rx;
    logic pend_off;
    rtw_apb_out_type apb;
    rtw_radio_out_type radio;
  } rtw_regs_type;

endpackage

// ### verif/rtw_seq_tb.sv
`timescale 1ns/10ps
module rtw_seq_tb import rtw_pkg::*; ;
  // Bit positions of the modem strobes inside the packed radio input
  localparam int P_SHR = 13;
  localparam int P_PHR = 12;
  localparam int P_AM = 11;
  localparam int P_END = 10;
  localparam int P_TXD = 7;
  // Clock, reset and design ports
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  rtw_apb_in_type apb_i = '0;
  rtw_apb_out_type apb_o;
  rtw_radio_in_type radio_i = '0;
  rtw_radio_out_type radio_o;
  // Counters, seed and model state
  int n_errors = 0;
  int checks_done = 0;
  int seed = 32'ha84d7ff7;
  int irq_seen [IRQ_N] = '{default: 0};
  int irq_exp [IRQ_N] = '{default: 0};
  int shr_seen = 0;
  int shr_exp = 0;
  int mask_m = 0;
  int len = 1;
  int wake_n [2] = '{40, 1250};
  logic [31:0] rd;
  logic err;

  // Free-running 50 MHz clock
  always #10 sys_clk_i = ~sys_clk_i;

  // Long counts shortened so the run stays brief
  rtw_seq #(.WAKE_COLD_P(40), .XOSC_P(30), .PLL_INIT_P(20)) dut_u (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .apb_i(apb_i),
    .apb_o(apb_o),
    .radio_i(radio_i),
    .radio_o(radio_o)
  );

  // Pulse monitor; values read here are those before the edge
  always @(posedge sys_clk_i) begin
    for (int i = 0; i < IRQ_N; i++) begin
      if (radio_o.irq[i] === 1'b1) irq_seen[i]++;
    end
    if (radio_o.shr_start === 1'b1) shr_seen++;
  end

  // Compare task for all results
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Model of the interrupt gate: an event counts only if unmasked and enabled
  task automatic ev(input int b);
    if (mask_m[b] && radio_i.gie) irq_exp[b]++;
  endtask

  // Event counts of the model against the monitor
  task automatic chk_ev();
    for (int i = 0; i < IRQ_N; i++) chk("irq count", 32'(irq_exp[i]), 32'(irq_seen[i]));
    chk("sync start count", 32'(shr_exp), 32'(shr_seen));
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int t;
    t = 0;
    @(posedge sys_clk_i);
    apb_i <= '{1'b1, 1'b0, wr, a, wd};
    @(posedge sys_clk_i);
    apb_i.penable <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      t++;
    end while (apb_o.pready !== 1'b1 && t < 20);
    rd = apb_o.prdata;
    err = apb_o.pslverr;
    apb_i <= '0;
    chk("pready seen", 32'h1, 32'(t < 20));
  endtask

  // Read a register and compare it
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), exp, rd);
  endtask

  // Poll status until the transition code clears, bounded
  task automatic wait_ready(input int lim);
    int k;
    k = 0;
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      k++;
    end while (rd[4:0] === STS_TRANS && k < lim);
    chk("transition ends", 32'h1, 32'(k < lim));
  endtask

  // One-cycle strobe on a modem input
  task automatic pulse(input int k);
    @(posedge sys_clk_i);
    radio_i[k] <= 1'b1;
    @(posedge sys_clk_i);
    radio_i[k] <= 1'b0;
  endtask

  // Summary and verdict
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Hang guard, well above the expected run length
  initial begin
    #(20 * 60000);
    n_errors++;
    $display("[FAIL] watchdog expected finish seen timeout");
    test_done();
  end

  // Main sequence
  initial begin
    repeat (8) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    rdchk(ADDR_STATUS, 32'(STS_OFF));
    rdchk(ADDR_CMD, 32'h0);
    rdchk(ADDR_MASK, 32'h0);
    rdchk(ADDR_PIN, 32'h0);
    rdchk(ADDR_CFG, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    // Start refused outside synthesizer-on; unknown codes have no effect
    apb(1'b1, ADDR_CMD, 32'(CMD_TX_START));
    rdchk(ADDR_STATUS, 32'(STS_OFF));
    apb(1'b1, ADDR_CMD, {27'h0, 1'b1, 4'($random(seed))});
    rdchk(ADDR_STATUS, 32'(STS_OFF));
    // Enable all interrupts, then ramp the synthesizer
    radio_i.gie <= 1'b1;
    mask_m = 32'h3f;
    apb(1'b1, ADDR_MASK, 32'h3f);
    apb(1'b1, ADDR_CMD, 32'(CMD_PLL_ON));
    rdchk(ADDR_STATUS, 32'(STS_TRANS));
    apb(1'b1, ADDR_CMD, 32'(CMD_FORCE_OFF));
    wait_ready(100);
    rdchk(ADDR_STATUS, 32'(STS_PLL_ON));
    ev(IRQ_LOCK);
    // Transmit by command; a listen command during it is held
    len = 1 + ($random(seed) & 32'h7e);
    radio_i.tx_len <= 7'(len);
    apb(1'b1, ADDR_CMD, 32'(CMD_TX_START));
    rdchk(ADDR_STATUS, 32'(STS_BUSY_TX));
    chk("amp on", 32'h1, {31'h0, radio_o.pa_en});
    chk("synth tx", 32'h1, {31'h0, radio_o.synth_tx});
    repeat (780) @(posedge sys_clk_i);
    chk_ev();
    repeat (40) @(posedge sys_clk_i);
    shr_exp++;
    chk_ev();
    apb(1'b1, ADDR_CMD, 32'(CMD_RX_ON));
    rdchk(ADDR_STATUS, 32'(STS_BUSY_TX));
    pulse(P_TXD);
    ev(IRQ_TX_DONE);
    repeat (2) @(posedge sys_clk_i);
    chk("amp off", 32'h0, {31'h0, radio_o.pa_en});
    rdchk(ADDR_STATUS, 32'(STS_TRANS));
    wait_ready(1000);
    rdchk(ADDR_STATUS, 32'(STS_RX_ON));
    chk_ev();
    // Basic mode frame with a failing filter still reports its end
    pulse(P_SHR);
    rdchk(ADDR_STATUS, 32'(STS_BUSY_RX));
    pulse(P_PHR);
    ev(IRQ_RX_START);
    pulse(P_AM);
    ev(IRQ_ADDR);
    pulse(P_END);
    ev(IRQ_RX_DONE);
    repeat (2) @(posedge sys_clk_i);
    chk_ev();
    // Extended mode: end reported only with filter pass and good FCS
    apb(1'b1, ADDR_CFG, 32'h1);
    for (int f = 0; f < 4; f++) begin
      radio_i.addr_pass <= f[0];
      radio_i.fcs_ok <= f[1];
      pulse(P_SHR);
      pulse(P_END);
      if (f == 3) ev(IRQ_RX_DONE);
    end
    repeat (2) @(posedge sys_clk_i);
    chk_ev();
    // Global enable off, then mask bit off, both silence the end event
    radio_i.gie <= 1'b0;
    pulse(P_SHR);
    pulse(P_END);
    radio_i.gie <= 1'b1;
    mask_m = 32'h3b;
    apb(1'b1, ADDR_MASK, 32'h3b);
    pulse(P_SHR);
    pulse(P_END);
    repeat (2) @(posedge sys_clk_i);
    chk_ev();
    mask_m = 32'h3f;
    apb(1'b1, ADDR_MASK, 32'h3f);
    // Plain off waits for the frame end
    pulse(P_SHR);
    apb(1'b1, ADDR_CMD, 32'(CMD_OFF));
    rdchk(ADDR_STATUS, 32'(STS_BUSY_RX));
    pulse(P_END);
    ev(IRQ_RX_DONE);
    rdchk(ADDR_STATUS, 32'(STS_OFF));
    // Converter already runs the regulator: short ramp, then listen
    radio_i.adc_analog_regulator_on <= 1'b1;
    apb(1'b1, ADDR_CMD, 32'(CMD_PLL_ON));
    rdchk(ADDR_STATUS, 32'(STS_PLL_ON));
    ev(IRQ_LOCK);
    apb(1'b1, ADDR_CMD, 32'(CMD_RX_ON));
    rdchk(ADDR_STATUS, 32'(STS_RX_ON));
    apb(1'b1, ADDR_CMD, 32'(CMD_OFF));
    radio_i.adc_analog_regulator_on <= 1'b0;
    // Listen from clock-only at once, then synthesizer-on without delay
    apb(1'b1, ADDR_CMD, 32'(CMD_RX_ON));
    rdchk(ADDR_STATUS, 32'(STS_RX_ON));
    chk("rx and regulator on", 32'h3, {30'h0, radio_o.rx_en, radio_o.analog_regulator_en});
    apb(1'b1, ADDR_CMD, 32'(CMD_PLL_ON));
    rdchk(ADDR_STATUS, 32'(STS_PLL_ON));
    // Trigger start with zero length aborts; trigger cleared by software
    radio_i.tx_len <= 7'h0;
    apb(1'b1, ADDR_PIN, 32'h1);
    rdchk(ADDR_STATUS, 32'(STS_BUSY_TX));
    repeat (810) @(posedge sys_clk_i);
    rdchk(ADDR_STATUS, 32'(STS_PLL_ON));
    apb(1'b1, ADDR_PIN, 32'h0);
    // Forced off in mid-frame aborts without a done event
    radio_i.tx_len <= 7'(len);
    apb(1'b1, ADDR_CMD, 32'(CMD_TX_START));
    repeat (820) @(posedge sys_clk_i);
    shr_exp++;
    apb(1'b1, ADDR_CMD, 32'(CMD_FORCE_OFF));
    rdchk(ADDR_STATUS, 32'(STS_OFF));
    chk_ev();
    // Wake from sleep, cold then warm oscillator
    for (int w = 0; w < 2; w++) begin
      radio_i.xosc_running <= w[0];
      apb(1'b1, ADDR_PIN, 32'h1);
      rdchk(ADDR_STATUS, 32'(STS_SLEEP));
      chk("osc off", 32'h0, {31'h0, radio_o.xosc_en});
      apb(1'b1, ADDR_PIN, 32'h0);
      repeat (wake_n[w] - 12) @(posedge sys_clk_i);
      chk("tuning on", 32'h1, {31'h0, radio_o.ftn_cal});
      rdchk(ADDR_STATUS, 32'(STS_TRANS));
      wait_ready(100);
      ev(IRQ_WAKE);
      rdchk(ADDR_STATUS, 32'(STS_OFF));
      chk_ev();
    end
    // Transceiver reset: self-release, long wake, registers cleared
    apb(1'b1, ADDR_PIN, 32'h2);
    repeat (1800) @(posedge sys_clk_i);
    rdchk(ADDR_STATUS, 32'(STS_TRANS));
    wait_ready(100);
    rdchk(ADDR_STATUS, 32'(STS_OFF));
    rdchk(ADDR_MASK, 32'h0);
    rdchk(ADDR_PIN, 32'h0);
    // Reset from sleep lasts longer and keeps the trigger bit
    apb(1'b1, ADDR_PIN, 32'h1);
    apb(1'b1, ADDR_PIN, 32'h3);
    repeat (1862) @(posedge sys_clk_i);
    rdchk(ADDR_STATUS, 32'(STS_TRANS));
    wait_ready(100);
    rdchk(ADDR_PIN, 32'h1);
    test_done();
  end
endmodule
